// File: logic/itf_filters.sv
/*
  Iris target and feedback filter section: APB registers, setpoint moving
  average, two cascaded feedback low-pass stages, error forming and an
  optional low-pass stage ahead of the PID controller.
  Assumes APB master on MCLK_IN and one ADC sample strobe per sample period.
*/
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// [R1] setpoint register at index 0 holds a 10-bit desired ADC value.
// [R2] setpoint code n means n/1023 of the reference supply, same scale as ADC.
// [R3] feedback stage one cut-off codes 0..3 give 2600/3600/5200/8000 Hz.
// [R4] feedback stage two has its own cut-off select with the same mapping.
// [R5] host should keep both feedback cut-off selects at code 0.
// [R6] setpoint moving average: length bit 0 averages 8, 1 averages 4.
// [R7] bypass bit 0 inserts the pre-controller low-pass, 1 bypasses it.
// [R8] pre-controller cut-off codes 0..6 give 900..4000 Hz; code 7 forbidden.
// [R9] on ringing the host may raise that cut-off or bypass the filter.
// [R10] error is averaged setpoint minus filtered feedback, sent through pre-filter.
module itf_filters #(
  parameter int unsigned SAMPLE_HZ = 100_000
) (
  input  wire logic                           MCLK_IN,
  input  wire logic                           RESET_N_IN,
  input  wire logic                           CE_IN,
  input  wire logic                           PSEL_IN,
  input  wire logic                           PENABLE_IN,
  input  wire logic                           PWRITE_IN,
  input  wire logic [itf_pkg::ADDR_W-1:0]     PADDR_IN,
  input  wire logic [31:0]                    PWDATA_IN,
  output logic      [31:0]                    PRDATA_OUT,
  output logic                                PREADY_OUT,
  output logic                                PSLVERR_OUT,
  input  wire logic [itf_pkg::SMP_W-1:0]      ADC_DATA_IN,
  input  wire logic                           ADC_VALID_IN,
  output logic signed [itf_pkg::ERR_W-1:0]    ERROR_OUT,
  output logic                                ERROR_VALID_OUT
);
  import itf_pkg::*;

  // coefficient must stay below one at the top cut-off
  if (SAMPLE_HZ < MIN_SAMPLE_HZ || SAMPLE_HZ > CLK_HZ) begin : g_bad_rate
    $error("itf_filters: SAMPLE_HZ out of range");
  end

  // ================================================================
  // APB slave
  logic              apb_access;
  logic              apb_commit;
  logic [5:0]        apb_idx;
  logic              pready_ff;
  logic              nxt_pready;
  logic              pslverr_ff;
  logic              nxt_pslverr;
  logic [31:0]       prdata_ff;
  logic [31:0]       nxt_prdata;

  logic [SMP_W-1:0]  setpoint_ff;
  logic [SMP_W-1:0]  nxt_setpoint;
  logic [CFG_W-1:0]  cfg_ff;
  logic [CFG_W-1:0]  nxt_cfg;

  logic [SMP_W-1:0]  avg_target;
  logic [COEF_FW:0]  fb1_coef;
  logic [COEF_FW:0]  fb2_coef;
  logic [COEF_FW:0]  pre_coef_w;
  logic              bypass;

  logic              err_vld_ff;
  logic              nxt_err_vld;
  logic signed [ERR_W-1:0] err_ff;
  logic signed [ERR_W-1:0] nxt_err;
  logic              out_vld_ff;
  logic              nxt_out_vld;
  logic signed [ERR_W-1:0] out_ff;
  logic signed [ERR_W-1:0] nxt_out;

  itf_smp_if #(.DW(ERR_W)) raw_if ();
  itf_smp_if #(.DW(ERR_W)) fb1_if ();
  itf_smp_if #(.DW(ERR_W)) fb2_if ();
  itf_smp_if #(.DW(ERR_W)) err_if ();
  itf_smp_if #(.DW(ERR_W)) pre_if ();

  function automatic logic [31:0] read_word(
    input logic [5:0]             idx,
    input logic [SMP_W-1:0]       sp,
    input logic [CFG_W-1:0]       cfg,
    input logic [ERR_W-1:0]       fb,
    input logic [ERR_W-1:0]       err
  );
    unique case (idx)
      IDX_SETPOINT:   return {22'h000000, sp};
      IDX_FILTER_CFG: return {23'h000000, cfg};
      IDX_FEEDBACK:   return {22'h000000, fb[SMP_W-1:0]};
      IDX_ERROR:      return {21'h000000, err};
      default:        return 32'h0000_0000;
    endcase
  endfunction

  assign apb_access = PSEL_IN && PENABLE_IN;
  // write lands only at the edge where the master sees pready high
  assign apb_commit = apb_access && pready_ff;
  assign apb_idx    = PADDR_IN[ADDR_W-1:2];

  always_comb begin
    nxt_pready  = 1'b0;
    nxt_pslverr = 1'b0;
    nxt_prdata  = prdata_ff;
    if (apb_access && !pready_ff) begin
      nxt_pready  = 1'b1;
      nxt_pslverr = !reg_mapped(PADDR_IN);
      if (!PWRITE_IN && reg_mapped(PADDR_IN)) begin
        nxt_prdata = read_word(apb_idx, setpoint_ff, cfg_ff, fb2_if.data, err_ff);
      end else begin
        nxt_prdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else if (CE_IN) begin
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end

  // ================================================================
  // control registers
  always_comb begin
    nxt_setpoint = setpoint_ff;
    nxt_cfg      = cfg_ff;
    if (apb_commit && PWRITE_IN && reg_mapped(PADDR_IN)) begin
      if (apb_idx == IDX_SETPOINT) begin
        nxt_setpoint = PWDATA_IN[SMP_W-1:0]; // [R1]
      end
      if (apb_idx == IDX_FILTER_CFG) begin
        nxt_cfg[FB1_LSB +: 2] = PWDATA_IN[FB1_LSB +: 2]; // [R3]
        nxt_cfg[FB2_LSB +: 2] = PWDATA_IN[FB2_LSB +: 2]; // [R4]
        nxt_cfg[AVG_BIT]      = PWDATA_IN[AVG_BIT]; // [R6]
        nxt_cfg[BYP_BIT]      = PWDATA_IN[BYP_BIT]; // [R7]
        // the forbidden code is dropped so the old cut-off stays in force
        if (PWDATA_IN[PRE_LSB +: 3] != PRE_CODE_FORBIDDEN) begin
          nxt_cfg[PRE_LSB +: 3] = PWDATA_IN[PRE_LSB +: 3]; // [R8]
        end
      end
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      setpoint_ff <= SETPOINT_RST;
      cfg_ff      <= CFG_RST;
    end else if (CE_IN) begin
      setpoint_ff <= nxt_setpoint;
      cfg_ff      <= nxt_cfg;
    end
  end

  assign fb1_coef   = fb_coef(cfg_ff[FB1_LSB +: 2], longint'(SAMPLE_HZ)); // [R3]
  assign fb2_coef   = fb_coef(cfg_ff[FB2_LSB +: 2], longint'(SAMPLE_HZ)); // [R4]
  assign pre_coef_w = pre_coef(cfg_ff[PRE_LSB +: 3], longint'(SAMPLE_HZ)); // [R8]
  assign bypass     = cfg_ff[BYP_BIT];

  // ================================================================
  // setpoint smoothing and feedback filters
  itf_mavg #(.DW(SMP_W), .DEPTH(AVG_DEPTH)) u_avg (
    .clk_in      (MCLK_IN),
    .rst_n_in    (RESET_N_IN),
    .ce_in       (CE_IN),
    .smp_in      (ADC_VALID_IN),
    .half_len_in (cfg_ff[AVG_BIT]),
    .target_in   (setpoint_ff),
    .avg_out     (avg_target)
  );

  // unsigned ADC code on the same n/1023 scale as the setpoint
  assign raw_if.valid = ADC_VALID_IN;
  assign raw_if.data  = $signed({1'b0, ADC_DATA_IN}); // [R2]

  itf_lpf #(.DW(ERR_W), .FW(COEF_FW)) u_fb1 (
    .clk_in   (MCLK_IN),
    .rst_n_in (RESET_N_IN),
    .ce_in    (CE_IN),
    .coef_in  (fb1_coef),
    .x_in     (raw_if),
    .y_out    (fb1_if)
  );

  itf_lpf #(.DW(ERR_W), .FW(COEF_FW)) u_fb2 (
    .clk_in   (MCLK_IN),
    .rst_n_in (RESET_N_IN),
    .ce_in    (CE_IN),
    .coef_in  (fb2_coef),
    .x_in     (fb1_if),
    .y_out    (fb2_if)
  );

  // ================================================================
  // error forming
  always_comb begin
    nxt_err_vld = fb2_if.valid;
    nxt_err     = err_ff;
    if (fb2_if.valid) begin
      nxt_err = $signed({1'b0, avg_target}) - fb2_if.data; // [R10] [R2]
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      err_vld_ff <= 1'b0;
      err_ff     <= '0;
    end else if (CE_IN) begin
      err_vld_ff <= nxt_err_vld;
      err_ff     <= nxt_err;
    end
  end

  assign err_if.valid = err_vld_ff;
  assign err_if.data  = err_ff;

  // filter keeps running while bypassed, so re-enabling starts from a warm state
  itf_lpf #(.DW(ERR_W), .FW(COEF_FW)) u_pre (
    .clk_in   (MCLK_IN),
    .rst_n_in (RESET_N_IN),
    .ce_in    (CE_IN),
    .coef_in  (pre_coef_w),
    .x_in     (err_if),
    .y_out    (pre_if)
  );

  // ================================================================
  // output select
  always_comb begin
    nxt_out_vld = bypass ? err_if.valid : pre_if.valid; // [R7]
    nxt_out     = out_ff;
    if (bypass && err_if.valid) begin
      nxt_out = err_if.data; // [R7]
    end else if (!bypass && pre_if.valid) begin
      nxt_out = pre_if.data; // [R10]
    end
  end

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      out_vld_ff <= 1'b0;
      out_ff     <= '0;
    end else if (CE_IN) begin
      out_vld_ff <= nxt_out_vld;
      out_ff     <= nxt_out;
    end
  end

  assign PRDATA_OUT      = prdata_ff;
  assign PREADY_OUT      = pready_ff;
  assign PSLVERR_OUT     = pslverr_ff;
  assign ERROR_OUT       = out_ff;
  assign ERROR_VALID_OUT = out_vld_ff;

  // ================================================================
  // checks
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  property p_setpoint_write;
    (CE_IN && apb_commit && PWRITE_IN && PADDR_IN == {IDX_SETPOINT, 2'h0})
      |=> (setpoint_ff == $past(PWDATA_IN[SMP_W-1:0])) ##1 (setpoint_ff == $past(setpoint_ff));
  endproperty
  a_setpoint_write: assert property (p_setpoint_write) else $error("setpoint write lost"); // [R1]

  property p_zero_error;
    (CE_IN && fb2_if.valid && fb2_if.data == $signed({1'b0, avg_target})) |=> (err_vld_ff && err_ff == 0);
  endproperty
  a_zero_error: assert property (p_zero_error) else $error("equal codes give nonzero error"); // [R2]

  property p_fb1_cutoff;
    (CE_IN && apb_commit && PWRITE_IN && PADDR_IN == {IDX_FILTER_CFG, 2'h0})
      |=> (fb1_coef == fb_coef($past(PWDATA_IN[FB1_LSB +: 2]), longint'(SAMPLE_HZ)));
  endproperty
  a_fb1_cutoff: assert property (p_fb1_cutoff) else $error("stage one cut-off not applied"); // [R3]

  property p_fb2_cutoff;
    (CE_IN && apb_commit && PWRITE_IN && PADDR_IN == {IDX_FILTER_CFG, 2'h0})
      |=> (fb2_coef == fb_coef($past(PWDATA_IN[FB2_LSB +: 2]), longint'(SAMPLE_HZ)));
  endproperty
  a_fb2_cutoff: assert property (p_fb2_cutoff) else $error("stage two cut-off not applied"); // [R4]

  property p_bypass_path;
    (CE_IN && bypass && err_if.valid) |=> (out_vld_ff && out_ff == $past(err_ff));
  endproperty
  a_bypass_path: assert property (p_bypass_path) else $error("bypass does not pass the error"); // [R7]

  property p_filtered_path;
    (CE_IN && !bypass && pre_if.valid) |=> (out_vld_ff && out_ff == $past(pre_if.data));
  endproperty
  a_filtered_path: assert property (p_filtered_path) else $error("filtered error not selected"); // [R7]

  property p_pre_code_legal;
    cfg_ff[PRE_LSB +: 3] != PRE_CODE_FORBIDDEN;
  endproperty
  a_pre_code_legal: assert property (p_pre_code_legal) else $error("forbidden cut-off code stored"); // [R8]

  property p_error_forming;
    (CE_IN && fb2_if.valid)
      |=> (err_vld_ff && err_ff == $signed({1'b0, $past(avg_target)}) - $past(fb2_if.data));
  endproperty
  a_error_forming: assert property (p_error_forming) else $error("error not formed from filtered feedback"); // [R10]

  property p_answer_one_wait;
    (CE_IN && apb_access && !pready_ff) |=> pready_ff;
  endproperty
  a_answer_one_wait: assert property (p_answer_one_wait) else $error("apb answer late");

  property p_freeze;
    !CE_IN |=> ($stable(setpoint_ff) && $stable(cfg_ff) && $stable(out_ff) && $stable(out_vld_ff));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

  property p_unmapped_err;
    (CE_IN && apb_access && !pready_ff && !reg_mapped(PADDR_IN))
      |=> (pready_ff && pslverr_ff && prdata_ff == 32'h0000_0000);
  endproperty
  a_unmapped_err: assert property (p_unmapped_err) else $error("unmapped access not refused");

  property p_forbidden_kept;
    (CE_IN && apb_commit && PWRITE_IN && PADDR_IN == {IDX_FILTER_CFG, 2'h0}
      && PWDATA_IN[PRE_LSB +: 3] == PRE_CODE_FORBIDDEN) |=> $stable(cfg_ff[PRE_LSB +: 3]);
  endproperty
  a_forbidden_kept: assert property (p_forbidden_kept) else $error("forbidden cut-off code took effect"); // [R8]

  c_bypass_out:  cover property (bypass && out_vld_ff);
  c_filter_out:  cover property (!bypass && out_vld_ff);
  c_forbid_wr:   cover property (apb_commit && PWRITE_IN && PWDATA_IN[PRE_LSB +: 3] == PRE_CODE_FORBIDDEN);
  c_short_avg:   cover property (cfg_ff[AVG_BIT] && ADC_VALID_IN);
  c_unmapped:    cover property (pready_ff && pslverr_ff);
endmodule
`default_nettype wire

// File: logic/itf_pkg.sv
/*
  Shared constants for the iris target and feedback filter block: register
  indices, field positions, reset values, cut-off tables and coefficient math.
  Assumes a 10 MHz system clock and a 10-bit ADC sample stream.
*/
package itf_pkg;
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned SMP_W         = 10;
  localparam int unsigned ERR_W         = 11;
  localparam int unsigned CFG_W         = 9;
  localparam int unsigned COEF_FW       = 16;
  localparam int unsigned AVG_DEPTH     = 8;
  localparam int unsigned MIN_SAMPLE_HZ = 60_000;
  localparam longint      TWO_PI_SCALED = 411775;

  // ================================================================
  // register indices; byte address is four times the index
  localparam logic [5:0] IDX_SETPOINT   = 6'h00;
  localparam logic [5:0] IDX_FILTER_CFG = 6'h01;
  localparam logic [5:0] IDX_FEEDBACK   = 6'h02;
  localparam logic [5:0] IDX_ERROR      = 6'h03;

  // ================================================================
  // filter configuration fields
  localparam int unsigned FB1_LSB = 0;
  localparam int unsigned FB2_LSB = 2;
  localparam int unsigned AVG_BIT = 4;
  localparam int unsigned BYP_BIT = 5;
  localparam int unsigned PRE_LSB = 6;

  localparam logic [SMP_W-1:0] SETPOINT_RST       = 10'h000;
  localparam logic [CFG_W-1:0] CFG_RST            = 9'h000;
  localparam logic [SMP_W-1:0] FULL_SCALE_CODE    = 10'h3ff;
  localparam logic [2:0]       PRE_CODE_FORBIDDEN = 3'h7;

  // ================================================================
  // cut-off frequencies in Hz
  localparam longint FB_HZ_0  = 2600;
  localparam longint FB_HZ_1  = 3600;
  localparam longint FB_HZ_2  = 5200;
  localparam longint FB_HZ_3  = 8000;
  localparam longint PRE_HZ_0 = 900;
  localparam longint PRE_HZ_1 = 1300;
  localparam longint PRE_HZ_2 = 1600;
  localparam longint PRE_HZ_3 = 2000;
  localparam longint PRE_HZ_4 = 2600;
  localparam longint PRE_HZ_5 = 3200;
  localparam longint PRE_HZ_6 = 4000;

  // small-angle one-pole gain: 2*pi*fc/fs in COEF_FW fraction bits
  function automatic logic [COEF_FW:0] lpf_coef(input longint hz, input longint fs);
    return (COEF_FW + 1)'((hz * TWO_PI_SCALED) / fs);
  endfunction

  function automatic logic [COEF_FW:0] fb_coef(input logic [1:0] code, input longint fs);
    unique case (code)
      2'h0: return lpf_coef(FB_HZ_0, fs);
      2'h1: return lpf_coef(FB_HZ_1, fs);
      2'h2: return lpf_coef(FB_HZ_2, fs);
      2'h3: return lpf_coef(FB_HZ_3, fs);
    endcase
  endfunction

  function automatic logic [COEF_FW:0] pre_coef(input logic [2:0] code, input longint fs);
    case (code)
      3'h1:    return lpf_coef(PRE_HZ_1, fs);
      3'h2:    return lpf_coef(PRE_HZ_2, fs);
      3'h3:    return lpf_coef(PRE_HZ_3, fs);
      3'h4:    return lpf_coef(PRE_HZ_4, fs);
      3'h5:    return lpf_coef(PRE_HZ_5, fs);
      3'h6:    return lpf_coef(PRE_HZ_6, fs);
      default: return lpf_coef(PRE_HZ_0, fs);
    endcase
  endfunction

  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a[ADDR_W-1:2] <= IDX_ERROR);
  endfunction
endpackage

// File: logic/itf_smp_if.sv
/*
  Sample stream carrier between filter stages: one valid strobe and a signed word.
  Assumes producer and consumer share the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface itf_smp_if #(parameter int unsigned DW = 11);
  logic                 valid;
  logic signed [DW-1:0] data;
  modport tx (output valid, output data);
  modport rx (input valid, input data);
endinterface
`default_nettype wire

// File: logic/itf_lpf.sv
/*
  One-pole low-pass stage with a run-time gain, updated once per input sample.
  Assumes the gain stays below one (COEF_FW fraction bits).
*/
`timescale 1ns/1ns
`default_nettype none
module itf_lpf #(
  parameter int unsigned DW = 11,
  parameter int unsigned FW = 16
) (
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          ce_in,
  input  wire logic [FW:0]   coef_in,
  itf_smp_if.rx              x_in,
  itf_smp_if.tx              y_out
);
  localparam int unsigned AW = DW + FW;

  logic signed [AW-1:0]    acc_ff;
  logic signed [AW-1:0]    nxt_acc;
  logic                    vld_ff;
  logic                    nxt_vld;
  logic signed [AW:0]      diff;
  logic signed [AW+FW+2:0] prod;

  // ================================================================
  // state update
  always_comb begin
    diff    = (AW+1)'($signed({x_in.data, {FW{1'b0}}})) - (AW+1)'(acc_ff);
    prod    = (AW+FW+3)'(diff) * (AW+FW+3)'($signed({1'b0, coef_in}));
    nxt_vld = x_in.valid;
    nxt_acc = acc_ff;
    if (x_in.valid) begin
      // step never exceeds the gap, so the cut back to AW bits is safe
      nxt_acc = acc_ff + AW'(prod >>> FW);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_ff <= '0;
      vld_ff <= 1'b0;
    end else if (ce_in) begin
      acc_ff <= nxt_acc;
      vld_ff <= nxt_vld;
    end
  end

  assign y_out.valid = vld_ff;
  assign y_out.data  = acc_ff[AW-1:FW];
endmodule
`default_nettype wire

// File: logic/itf_mavg.sv
/*
  Moving average of the iris setpoint over DEPTH or DEPTH/2 samples.
  Assumes a new setpoint sample is taken on each sample strobe.
*/
`timescale 1ns/1ns
`default_nettype none
module itf_mavg #(
  parameter int unsigned DW    = 10,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic          clk_in,
  input  wire logic          rst_n_in,
  input  wire logic          ce_in,
  input  wire logic          smp_in,
  input  wire logic          half_len_in,
  input  wire logic [DW-1:0] target_in,
  output logic      [DW-1:0] avg_out
);
  localparam int unsigned SW = DW + $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("itf_mavg: DEPTH must be a power of two of at least 2");
  end

  logic [DW-1:0] hist_ff [DEPTH];
  logic [DW-1:0] nxt_hist [DEPTH];
  logic [DW-1:0] avg_ff;
  logic [DW-1:0] nxt_avg;
  logic [SW-1:0] sum;

  // ================================================================
  // history and average
  always_comb begin
    sum = '0;
    for (int i = 0; i < DEPTH; i++) begin
      nxt_hist[i] = hist_ff[i];
      if (!half_len_in || i < DEPTH / 2) begin
        sum = sum + SW'(hist_ff[i]);
      end
    end
    if (smp_in) begin
      nxt_hist[0] = target_in;
      for (int i = 1; i < DEPTH; i++) begin
        nxt_hist[i] = hist_ff[i-1];
      end
    end
    nxt_avg = half_len_in ? DW'(sum >> ($clog2(DEPTH) - 1)) : DW'(sum >> $clog2(DEPTH)); // [R6]
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        hist_ff[i] <= '0;
      end
      avg_ff <= '0;
    end else if (ce_in) begin
      hist_ff <= nxt_hist;
      avg_ff  <= nxt_avg;
    end
  end

  assign avg_out = avg_ff;

  // ================================================================
  // checks
  property p_avg_flat;
    @(posedge clk_in) disable iff (!rst_n_in)
    (ce_in && half_len_in && hist_ff[0] == hist_ff[1] && hist_ff[1] == hist_ff[2] && hist_ff[2] == hist_ff[3])
      |=> (avg_ff == $past(hist_ff[0]));
  endproperty
  a_avg_flat: assert property (p_avg_flat) else $error("short average of equal samples differs"); // [R6]
endmodule
`default_nettype wire

// File: tb/itf_sensor_model.sv
/*
  Position sensor and converter model: one 10-bit code per PERIOD cycles.
  Assumes the bench sets the level and starts or stops the stream.
*/
`timescale 1ns/1ns
`default_nettype none
module itf_sensor_model #(
  parameter int PERIOD = 7
) (
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       run_in,
  input  wire logic [9:0] level_in,
  output logic      [9:0] data_out,
  output logic            valid_out
);
  int cnt;
  // ==========
  // code stream; the line toggles between samples so stale data shows
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 0;
      valid_out <= 1'b0;
      data_out <= 10'h155;
    end else if (run_in && cnt == PERIOD - 1) begin
      cnt <= 0;
      valid_out <= 1'b1;
      data_out <= level_in;
    end else begin
      cnt <= run_in ? cnt + 1 : 0;
      valid_out <= 1'b0;
      data_out <= ~data_out;
    end
  end
endmodule
`default_nettype wire

// File: tb/itf_filters_test.sv
/*
  Self-checking bench: APB register checks and a sample-level model of the
  average, the feedback filters and the pre-controller stage.
  Assumes the design and sensor model share one 10 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module itf_filters_test;
  import itf_pkg::*;
  localparam int FS = 100_000;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic [9:0]        level = 10'h000;
  logic [9:0]        adc;
  logic              adc_v;
  logic              run = 1'b0;
  logic              ce = 1'b1;
  int                act = 0;
  logic signed [10:0] err;
  logic              err_v;
  logic [CFG_W-1:0]  cfg = 9'h000;
  int                mismatches = 0;
  int                total_checks = 0;
  int                cyc = 0;
  int                sp = 0;
  int                hist[8] = '{default: 0};
  int                fbhz[4] = '{2600, 3600, 5200, 8000};
  int                prehz[8] = '{900, 1300, 1600, 2000, 2600, 3200, 4000, 900};
  int                qv[$];
  int                qc[$];
  int                ql[$];
  int                s, n, e;
  longint            a1 = 0, a2 = 0, ap = 0;

  always #50 clk = ~clk;

  itf_filters #(.SAMPLE_HZ(FS)) i_dut (
    .MCLK_IN(clk), .RESET_N_IN(rst_n), .CE_IN(ce), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .ADC_DATA_IN(adc), .ADC_VALID_IN(adc_v),
    .ERROR_OUT(err), .ERROR_VALID_OUT(err_v));

  itf_sensor_model #(.PERIOD(7)) i_sensor (
    .clk_in(clk), .rst_n_in(rst_n), .run_in(run), .level_in(level), .data_out(adc), .valid_out(adc_v));

  // ==========
  // checking
  task automatic chk(input string nm, input int ex, input logic signed [31:0] sn, input int tol);
    total_checks++;
    if ($isunknown(sn) || sn - ex > tol || ex - sn > tol) begin
      mismatches++;
      $display("Error %s expected %0d seen %0d", nm, ex, sn);
    end
  endtask

  task end_sim;
    if (mismatches == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  function automatic longint lp(longint a, longint x, int hz);
    return a + ((((x <<< 16) - a) * (longint'(hz) * TWO_PI_SCALED / FS)) >>> 16);
  endfunction

  // ==========
  // apb master; releases only at the edge that samples pready high
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    int w;
    w = 0;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      w++;
    end while (pready !== 1'b1 && w < 50);
    if (w >= 50) chk("pready", 1, 0, 0);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input int xe);
    logic [31:0] r;
    logic er;
    apb(1'b1, a, d, r, er);
    chk("pslverr", xe, {31'h0, er}, 0);
    if (a == 8'h00) sp = int'(d[9:0]);
    if (a == 8'h04) cfg = (d[8:6] == PRE_CODE_FORBIDDEN) ? {cfg[8:6], d[5:0]} : d[8:0];
  endtask

  task automatic rd(input logic [7:0] a, input int ex, input int xe, input int tol);
    logic [31:0] r;
    logic er;
    apb(1'b0, a, 32'h0, r, er);
    chk("pslverr", xe, {31'h0, er}, 0);
    chk("prdata", ex, r, tol);
  endtask

  // ==========
  // sample-level model, one step per strobe taken
  always @(negedge clk) begin
    // a strobe counts only when the enable lets the design take it
    if (rst_n && adc_v && ce) begin
      for (int i = 7; i > 0; i--) hist[i] = hist[i-1];
      hist[0] = sp;
      n = cfg[AVG_BIT] ? 4 : 8;
      s = 0;
      for (int i = 0; i < n; i++) s += hist[i];
      a1 = lp(a1, adc, fbhz[cfg[1:0]]);
      a2 = lp(a2, a1 >>> 16, fbhz[cfg[3:2]]);
      e = s / n - int'(a2 >>> 16);
      ap = lp(ap, e, prehz[cfg[8:6]]);
      qv.push_back(cfg[BYP_BIT] ? e : int'(ap >>> 16));
      qc.push_back(act);
      ql.push_back(cfg[BYP_BIT] ? 4 : 5);
    end
    if (rst_n && err_v && ce) begin
      if (qv.size() == 0) chk("error_valid", 0, 1, 0);
      else begin
        chk("error_out", qv.pop_front(), err, 3);
        chk("latency", ql.pop_front(), act - qc.pop_front(), 0);
      end
    end
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    act <= act + int'(ce);
    // enable only stutters while the sample stream runs, never under a bus transfer
    ce <= run ? ($urandom_range(7, 0) != 0) : 1'b1;
    level <= 10'($urandom_range(1023, 0));
    if (cyc > 20000) begin
      mismatches++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(32'h31a20f09));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 0, 0, 0);
    rd(8'h04, 0, 0, 0);
    wr(8'h00, 32'hffffffff, 0);
    rd(8'h00, 1023, 0, 0);
    wr(8'h04, 32'h000001f9, 0);
    rd(8'h04, 32'h39, 0, 0);
    wr(8'h10, 32'h5, 1);
    rd(8'h02, 0, 1, 0);
    wr(8'h08, 32'h3ff, 0);
    for (int i = 0; i < 8; i++) begin
      // code 0 first as the host default, later higher cut-offs and bypass
      wr(8'h04, {23'h0, 3'(i % 7), 1'(i >= 6), 1'(i % 2), 2'((i / 2) % 4), 2'(i % 4)}, 0);
      wr(8'h00, {22'h0, 10'($urandom_range(1023, 0))}, 0);
      run <= 1'b1;
      repeat (84) @(posedge clk);
      run <= 1'b0;
      repeat (10) @(posedge clk);
      rd(8'h08, int'(a2 >>> 16), 0, 3);
      rd(8'h0c, e & 32'h7ff, 0, 0);
    end
    chk("pending", 0, qv.size(), 0);
    end_sim();
  end
endmodule
`default_nettype wire
